//--- common/pfpp_pkg.sv
package pfpp_pkg;

  // ==========================================================================
  // Bus widths
  // ==========================================================================
  localparam int unsigned DATA_W = 16;
  localparam int unsigned SEL_W  = 4;
  localparam int unsigned ADDR_W = 32;

  // ==========================================================================
  // Field selector codes
  // ==========================================================================
  localparam logic [3:0] SEL_CMD       = 4'h0;
  localparam logic [3:0] SEL_ADDR_LO   = 4'h1;
  localparam logic [3:0] SEL_ADDR_NEXT = 4'h2;
  localparam logic [3:0] SEL_DATA      = 4'h5;

  // ==========================================================================
  // Command words
  // ==========================================================================
  localparam logic [15:0] CMD_READ          = 16'h0011;
  localparam logic [15:0] CMD_PAGE_WR       = 16'h0012;
  localparam logic [15:0] CMD_PAGE_WR_LOCK  = 16'h0022;
  localparam logic [15:0] CMD_PAGE_ER_WR    = 16'h0032;
  localparam logic [15:0] CMD_PAGE_ER_WR_LK = 16'h0042;
  localparam logic [15:0] CMD_ERASE_ALL     = 16'h0013;
  localparam logic [15:0] CMD_SET_LOCK      = 16'h0014;
  localparam logic [15:0] CMD_CLEAR_LOCK    = 16'h0024;
  localparam logic [15:0] CMD_GET_LOCK      = 16'h0015;
  localparam logic [15:0] CMD_SET_GP_BIT    = 16'h0034;
  localparam logic [15:0] CMD_CLEAR_GP_BIT  = 16'h0044;
  localparam logic [15:0] CMD_GET_GP_BIT    = 16'h0025;
  localparam logic [15:0] CMD_SET_SECURE    = 16'h0054;
  localparam logic [15:0] CMD_GET_SECURE    = 16'h0035;
  localparam logic [15:0] CMD_MEM_WRITE     = 16'h001F;
  localparam logic [15:0] CMD_GET_REVISION  = 16'h001E;
  localparam logic [15:0] CMD_PICK_CTRL     = 16'h0016;

  // Decoded operation classes handed to the flash back end
  typedef enum logic [3:0] {
    PFPP_OP_NONE, PFPP_OP_READ, PFPP_OP_WRITE, PFPP_OP_ERASE_ALL,
    PFPP_OP_SET_LOCK, PFPP_OP_CLR_LOCK, PFPP_OP_GET_LOCK,
    PFPP_OP_SET_GP, PFPP_OP_CLR_GP, PFPP_OP_GET_GP,
    PFPP_OP_SET_SEC, PFPP_OP_GET_SEC, PFPP_OP_MEM_WR,
    PFPP_OP_GET_REV, PFPP_OP_PICK_CTRL
  } pfpp_op_e;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int unsigned CLK_MHZ        = 250;
  // Ext clock above 32 kHz: at most 31.25 us between its edges
  localparam int unsigned EXT_PERIOD_NS  = 31250;
  localparam int unsigned EXT_TIMEOUT_CY = EXT_PERIOD_NS * CLK_MHZ / 1000;
  // Host hold after power-up before first handshake
  localparam int unsigned POR_WAIT_US    = 100;
  localparam int unsigned POR_WAIT_CY    = POR_WAIT_US * CLK_MHZ;
  // Host-side settle time between line changes
  localparam int unsigned SETTLE_CY      = 2;

endpackage

//--- common/pfpp_if.sv
`timescale 1ns/1ps
interface pfpp_if;
  import pfpp_pkg::*;

  logic              cmd_strobe_n;
  logic              read_enable_n;
  logic [SEL_W-1:0]  field_selector;
  logic [DATA_W-1:0] host_data_o;
  logic              host_data_oe;
  logic              ready_out;
  logic              ready_oe;
  logic              out_flag_n;
  logic              out_flag_oe;
  logic [DATA_W-1:0] dev_data_o;
  logic              dev_data_oe;
  logic [DATA_W-1:0] prog_data_bus;

  // Resolved bus level; undriven lines float high like a pull-up
  assign prog_data_bus = dev_data_oe  ? dev_data_o  :
                         host_data_oe ? host_data_o : '1;

  modport device (
    input  cmd_strobe_n, read_enable_n, field_selector, prog_data_bus,
    output ready_out, ready_oe, out_flag_n, out_flag_oe,
    output dev_data_o, dev_data_oe
  );
  modport host (
    output cmd_strobe_n, read_enable_n, field_selector,
    output host_data_o, host_data_oe,
    input  ready_out, ready_oe, out_flag_n, out_flag_oe, prog_data_bus
  );
endinterface

//--- design/pfpp_clk_detect.sv
`timescale 1ns/1ps
module pfpp_clk_detect
  import pfpp_pkg::*;
#(
  parameter int unsigned TIMEOUT_CY = EXT_TIMEOUT_CY
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic reset_n,
  input  wire logic clk_en,
  // Sampled external clock level
  input  wire logic ext_clock_in,
  // Result
  output logic      ext_present
);

  typedef struct packed {
    logic        s1;
    logic        s2;
    logic        s3;
    logic [15:0] cnt;
    logic        seen;
  } pfpp_det_s;

  pfpp_det_s st_q, st_d;

  // ==========================================================================
  // Edge watch
  // ==========================================================================
  // Present from each edge until a timeout passes with no further edge
  always_comb begin
    st_d    = st_q;
    st_d.s1 = ext_clock_in;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    if (st_q.s2 != st_q.s3) begin
      st_d.cnt  = '0;
      st_d.seen = 1'b1;
    end else if (st_q.cnt == TIMEOUT_CY[15:0]) begin
      st_d.seen = 1'b0;
    end else begin
      st_d.cnt = st_q.cnt + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) st_q <= '0;
    else if (clk_en) st_q <= st_d;
  end

  assign ext_present = st_q.seen;

endmodule // pfpp_clk_detect

//--- design/pfpp_device.sv
`timescale 1ns/1ps
module pfpp_device
  import pfpp_pkg::*;
#(
  parameter int unsigned EXT_TIMEOUT = EXT_TIMEOUT_CY
) (
  // Clock, reset, enable
  input  wire logic              sys_clk,
  input  wire logic              reset_n,
  input  wire logic              clk_en,
  // Mode straps and external clock
  input  wire logic              test_select,
  input  wire logic              prog_enable_a,
  input  wire logic              prog_enable_b,
  input  wire logic              ext_clock_in,
  // Programming port
  pfpp_if.device                 port,
  // Flash back end request
  output logic                   op_start,
  output pfpp_op_e               op_kind,
  output logic [ADDR_W-1:0]      op_addr,
  output logic [DATA_W-1:0]      op_wdata,
  input  wire logic              op_done,
  input  wire logic [DATA_W-1:0] op_rdata,
  // Status
  output logic                   prog_mode,
  output logic                   ext_clk_sel
);

  typedef enum logic [2:0] {
    ST_OFF, ST_IDLE, ST_EXEC, ST_RD_WAIT, ST_RD_DRIVE, ST_RELEASE
  } pfpp_dev_e;

  typedef struct packed {
    pfpp_dev_e         state;
    logic              rdy;
    logic              rdy_oe;
    logic              flag_n;
    logic              flag_oe;
    logic [DATA_W-1:0] dout;
    logic              doe;
    logic [SEL_W-1:0]  sel;
    logic [DATA_W-1:0] word;
    logic [DATA_W-1:0] cmd;
    logic [ADDR_W-1:0] addr;
    logic              start;
    pfpp_op_e          kind;
    logic [DATA_W-1:0] wdata;
    logic              mode;
    logic              clk_sel;
    logic              pend_wr;
  } pfpp_dev_s;

  pfpp_dev_s st_q, st_d;
  logic      ext_present;

  // ==========================================================================
  // Command decode
  // ==========================================================================
  function automatic pfpp_op_e cmd_decode(input logic [DATA_W-1:0] c);
    unique case (c)
      CMD_READ:          cmd_decode = PFPP_OP_READ;
      CMD_PAGE_WR,
      CMD_PAGE_WR_LOCK,
      CMD_PAGE_ER_WR,
      CMD_PAGE_ER_WR_LK: cmd_decode = PFPP_OP_WRITE;
      CMD_ERASE_ALL:     cmd_decode = PFPP_OP_ERASE_ALL;
      CMD_SET_LOCK:      cmd_decode = PFPP_OP_SET_LOCK;
      CMD_CLEAR_LOCK:    cmd_decode = PFPP_OP_CLR_LOCK;
      CMD_GET_LOCK:      cmd_decode = PFPP_OP_GET_LOCK;
      CMD_SET_GP_BIT:    cmd_decode = PFPP_OP_SET_GP;
      CMD_CLEAR_GP_BIT:  cmd_decode = PFPP_OP_CLR_GP;
      CMD_GET_GP_BIT:    cmd_decode = PFPP_OP_GET_GP;
      CMD_SET_SECURE:    cmd_decode = PFPP_OP_SET_SEC;
      CMD_GET_SECURE:    cmd_decode = PFPP_OP_GET_SEC;
      CMD_MEM_WRITE:     cmd_decode = PFPP_OP_MEM_WR;
      CMD_GET_REVISION:  cmd_decode = PFPP_OP_GET_REV;
      CMD_PICK_CTRL:     cmd_decode = PFPP_OP_PICK_CTRL;
      default:           cmd_decode = PFPP_OP_NONE;
    endcase
  endfunction

  // Commands whose data phase reads the flash back end
  function automatic logic is_read_op(input pfpp_op_e k);
    is_read_op = (k == PFPP_OP_READ) || (k == PFPP_OP_GET_LOCK) ||
                 (k == PFPP_OP_GET_GP) || (k == PFPP_OP_GET_SEC) ||
                 (k == PFPP_OP_GET_REV);
  endfunction

  pfpp_clk_detect #(
    .TIMEOUT_CY (EXT_TIMEOUT)
  ) u_det (
    .sys_clk      (sys_clk),
    .reset_n      (reset_n),
    .clk_en       (clk_en),
    .ext_clock_in (ext_clock_in),
    .ext_present  (ext_present)
  );

  // ==========================================================================
  // Handshake engine
  // ==========================================================================
  // Interlocked: every port step waits on the host's level, so host speed is free
  always_comb begin
    pfpp_op_e k;
    k        = cmd_decode(st_q.cmd);
    st_d       = st_q;
    st_d.start = 1'b0;
    unique case (st_q.state)
      ST_OFF: begin
        // Lines stay undriven until all three enables are high
        if (test_select && prog_enable_a && prog_enable_b) begin
          st_d.mode    = 1'b1;
          st_d.rdy     = 1'b1;
          st_d.rdy_oe  = 1'b1;
          st_d.flag_n  = 1'b0;
          st_d.flag_oe = 1'b1;
          st_d.state   = ST_IDLE;
        end
      end
      ST_IDLE: begin
        // Strobe only honoured here, where ready is high
        if (!port.cmd_strobe_n) begin
          st_d.sel     = port.field_selector;
          st_d.word    = port.prog_data_bus;
          st_d.rdy     = 1'b0;
          st_d.clk_sel = st_q.clk_sel | ext_present;
          st_d.state   = ST_EXEC;
        end
      end
      ST_EXEC: begin
        unique case (st_q.sel)
          SEL_CMD: begin
            // Flush a pending page load before taking a new command
            if (st_q.pend_wr) begin
              st_d.pend_wr = 1'b0;
              st_d.start   = 1'b1;
              st_d.kind    = PFPP_OP_WRITE;
              st_d.state   = ST_RD_WAIT;
            end else begin
              st_d.cmd   = st_q.word;
              st_d.state = ST_RELEASE;
            end
          end
          SEL_ADDR_LO: begin
            st_d.addr  = {st_q.addr[ADDR_W-1:8], st_q.word[7:0]};
            st_d.state = ST_RELEASE;
          end
          SEL_ADDR_NEXT: begin
            st_d.addr  = {st_q.addr[ADDR_W-1:16], st_q.word};
            st_d.state = ST_RELEASE;
          end
          SEL_DATA: begin
            st_d.kind  = k;
            st_d.wdata = st_q.word;
            st_d.start = 1'b1;
            if (k == PFPP_OP_WRITE) st_d.pend_wr = 1'b1;
            st_d.state = ST_RD_WAIT;
          end
          default: st_d.state = ST_RELEASE;
        endcase
      end
      ST_RD_WAIT: begin
        // Back end completes; flush returns to re-run the command word
        if (op_done) begin
          if (st_q.sel == SEL_CMD) begin
            st_d.state = ST_EXEC;
          end else begin
            st_d.dout  = op_rdata;
            st_d.addr  = st_q.addr + 32'h0000_0001;
            st_d.state = is_read_op(st_q.kind) ? ST_RD_DRIVE : ST_RELEASE;
          end
        end
      end
      ST_RD_DRIVE: begin
        if (!port.read_enable_n && !st_q.doe) begin
          st_d.doe    = 1'b1;
          st_d.flag_n = 1'b1;
        end else if (port.read_enable_n && st_q.doe) begin
          st_d.doe    = 1'b0;
          st_d.flag_n = 1'b0;
          st_d.state  = ST_RELEASE;
        end
      end
      ST_RELEASE: begin
        if (port.cmd_strobe_n) begin
          st_d.rdy   = 1'b1;
          st_d.state = ST_IDLE;
        end
      end
      default: st_d.state = ST_OFF;
    endcase
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      st_q       <= '0;
      st_q.state <= ST_OFF;
      st_q.kind  <= PFPP_OP_NONE;
      st_q.rdy   <= 1'b1;
      st_q.flag_n <= 1'b1;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state register
  assign port.ready_out   = st_q.rdy;
  assign port.ready_oe    = st_q.rdy_oe;
  assign port.out_flag_n  = st_q.flag_n;
  assign port.out_flag_oe = st_q.flag_oe;
  assign port.dev_data_o  = st_q.dout;
  assign port.dev_data_oe = st_q.doe;
  assign op_start         = st_q.start;
  assign op_kind          = st_q.kind;
  assign op_addr          = st_q.addr;
  assign op_wdata         = st_q.wdata;
  assign prog_mode        = st_q.mode;
  assign ext_clk_sel      = st_q.clk_sel;

endmodule // pfpp_device

//--- design/pfpp_host.sv
`timescale 1ns/1ps
module pfpp_host
  import pfpp_pkg::*;
#(
  parameter int unsigned POR_CY = POR_WAIT_CY
) (
  // Clock, reset, enable
  input  wire logic              sys_clk,
  input  wire logic              reset_n,
  input  wire logic              clk_en,
  // Programming port
  pfpp_if.host                   port,
  // User request
  input  wire logic              req_valid,
  input  wire logic              req_read,
  input  wire logic [SEL_W-1:0]  req_sel,
  input  wire logic [DATA_W-1:0] req_data,
  output logic                   req_ready,
  output logic                   rsp_valid,
  output logic [DATA_W-1:0]      rsp_data
);

  typedef enum logic [2:0] {
    H_POR, H_IDLE, H_WAIT_LO, H_RD_OE, H_RD_VAL, H_RD_OFF, H_WAIT_HI
  } pfpp_host_e;

  typedef struct packed {
    pfpp_host_e        state;
    logic [31:0]       cnt;
    logic              rd;
    logic              strobe_n;
    logic              oe_n;
    logic [SEL_W-1:0]  sel;
    logic [DATA_W-1:0] dout;
    logic              doe;
    logic              rvalid;
    logic [DATA_W-1:0] rdata;
    logic              rdy;
  } pfpp_host_s;

  pfpp_host_s st_q, st_d;

  // ==========================================================================
  // Handshake sequencer
  // ==========================================================================
  always_comb begin
    st_d        = st_q;
    st_d.rvalid = 1'b0;
    unique case (st_q.state)
      H_POR: begin
        // Wait out power-on time before the first handshake
        if (st_q.cnt == POR_CY - 1) begin
          st_d.rdy   = 1'b1;
          st_d.state = H_IDLE;
        end else begin
          st_d.cnt = st_q.cnt + 32'h0000_0001;
        end
      end
      H_IDLE: begin
        if (req_valid && st_q.rdy && port.ready_out) begin
          st_d.rdy      = 1'b0;
          st_d.rd       = req_read;
          st_d.sel      = req_sel;
          st_d.dout     = req_data;
          st_d.doe      = 1'b1;
          st_d.state    = H_WAIT_LO;
        end
      end
      H_WAIT_LO: begin
        // Strobe falls one cycle after the lines, so they settle first
        if (st_q.strobe_n) begin
          st_d.strobe_n = 1'b0;
        end else if (!port.ready_out) begin
          st_d.doe   = 1'b0;
          // Write: lines released here, strobe rises a cycle later
          st_d.state = st_q.rd ? H_RD_OE : H_RD_OFF;
        end
      end
      H_RD_OE: begin
        st_d.oe_n  = 1'b0;
        st_d.state = H_RD_VAL;
      end
      H_RD_VAL: begin
        if (port.out_flag_n) begin
          st_d.rdata  = port.prog_data_bus;
          st_d.rvalid = 1'b1;
          st_d.oe_n   = 1'b1;
          st_d.state  = H_RD_OFF;
        end
      end
      H_RD_OFF: begin
        if (!port.out_flag_n) begin
          st_d.strobe_n = 1'b1;
          st_d.state    = H_WAIT_HI;
        end
      end
      H_WAIT_HI: begin
        if (port.ready_out) begin
          st_d.rdy   = 1'b1;
          st_d.state = H_IDLE;
        end
      end
      default: st_d.state = H_POR;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      st_q          <= '0;
      st_q.state    <= H_POR;
      st_q.strobe_n <= 1'b1;
      st_q.oe_n     <= 1'b1;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  assign port.cmd_strobe_n   = st_q.strobe_n;
  assign port.read_enable_n  = st_q.oe_n;
  assign port.field_selector = st_q.sel;
  assign port.host_data_o    = st_q.dout;
  assign port.host_data_oe   = st_q.doe;
  assign req_ready           = st_q.rdy;
  assign rsp_valid           = st_q.rvalid;
  assign rsp_data            = st_q.rdata;

endmodule // pfpp_host

//--- bench/pfpp_properties.sv
`timescale 1ns/1ps
// ==========================================================================
// Link properties between the host end and the device end
// ==========================================================================
module pfpp_checker
  import pfpp_pkg::*;
(
  // Clock and reset
  input wire logic              sys_clk,
  input wire logic              reset_n,
  // Host-driven lines
  input wire logic              cmd_strobe_n,
  input wire logic              read_enable_n,
  input wire logic [SEL_W-1:0]  field_selector,
  input wire logic [DATA_W-1:0] host_data_o,
  input wire logic              host_data_oe,
  // Device-driven lines
  input wire logic              ready_out,
  input wire logic              ready_oe,
  input wire logic              out_flag_n,
  input wire logic              out_flag_oe,
  input wire logic              dev_data_oe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  // Reset itself is the cause here, so this one is never disabled
  a_reset_lines_free: assert property (disable iff (1'b0)
    !reset_n |=> !ready_oe && !out_flag_oe && !dev_data_oe)
    else $error("device drives a port line during reset");
  a_ready_drops_take: assert property (
    ready_oe && ready_out && !cmd_strobe_n |=> !ready_out)
    else $error("ready did not drop one cycle after a take");
  a_ready_waits_strobe: assert property (
    ready_oe && !ready_out && !cmd_strobe_n |=> !ready_out)
    else $error("ready rose while the strobe was still low");
  a_ready_steady_idle: assert property (
    ready_oe && ready_out && cmd_strobe_n |=> ready_out)
    else $error("ready dropped with no request");
  a_ready_rise_bound: assert property (
    $rose(cmd_strobe_n) |-> ##[1:40] ready_out)
    else $error("ready did not return after the strobe rose");
  a_host_waits_ready: assert property (
    $fell(cmd_strobe_n) |-> $past(ready_out))
    else $error("strobe lowered while the device was busy");
  a_host_holds_lines: assert property (
    !cmd_strobe_n && ready_out |=> $stable(field_selector)
      && $stable(host_data_o) && $stable(host_data_oe))
    else $error("host changed its lines before ready dropped");
  a_flag_tracks_drive: assert property (
    out_flag_oe |-> out_flag_n == dev_data_oe)
    else $error("valid flag disagrees with the bus direction");
  a_drive_needs_oe: assert property (
    dev_data_oe |-> !$past(read_enable_n) && !host_data_oe)
    else $error("device drives the bus without read enable");

  // Main scenarios seen on the wire
  c_take: cover property ($fell(ready_out));
  c_read_drive: cover property ($rose(dev_data_oe));
  c_full: cover property ($fell(cmd_strobe_n) ##[1:60] $rose(ready_out));
endmodule // pfpp_checker

//--- bench/parallel_flash_programming_port_tb.sv
`timescale 1ns/1ps
module parallel_flash_programming_port_tb;
  import pfpp_pkg::*;
  // ========================================================================
  // Signals
  // ========================================================================
  logic sys_clk, reset_n, clk_en, test_select;
  logic prog_enable_a, prog_enable_b, ext_clock_in;
  logic req_valid, req_read, req_ready, rsp_valid;
  logic [SEL_W-1:0]  req_sel;
  logic [DATA_W-1:0] req_data, rsp_data, op_wdata, op_rdata;
  logic op_start, op_done, prog_mode, ext_clk_sel;
  pfpp_op_e          op_kind, seen_kind;
  logic [ADDR_W-1:0] op_addr;
  int                failures, n_checks, n_ops, ext_div, base;
  logic [2:0]        be_cnt;
  logic [15:0]       seen_addr, seen_wdata, exp_addr, rd_word;
  // Command words with the class and direction each must decode to
  localparam logic [15:0] CMD_TAB [17] = '{CMD_READ, CMD_PAGE_WR,
    CMD_PAGE_WR_LOCK, CMD_PAGE_ER_WR, CMD_PAGE_ER_WR_LK, CMD_ERASE_ALL,
    CMD_SET_LOCK, CMD_CLEAR_LOCK, CMD_GET_LOCK, CMD_SET_GP_BIT,
    CMD_CLEAR_GP_BIT, CMD_GET_GP_BIT, CMD_SET_SECURE, CMD_GET_SECURE,
    CMD_MEM_WRITE, CMD_GET_REVISION, CMD_PICK_CTRL};
  localparam pfpp_op_e KIND_TAB [17] = '{PFPP_OP_READ, PFPP_OP_WRITE,
    PFPP_OP_WRITE, PFPP_OP_WRITE, PFPP_OP_WRITE, PFPP_OP_ERASE_ALL,
    PFPP_OP_SET_LOCK, PFPP_OP_CLR_LOCK, PFPP_OP_GET_LOCK, PFPP_OP_SET_GP,
    PFPP_OP_CLR_GP, PFPP_OP_GET_GP, PFPP_OP_SET_SEC, PFPP_OP_GET_SEC,
    PFPP_OP_MEM_WR, PFPP_OP_GET_REV, PFPP_OP_PICK_CTRL};
  localparam logic [16:0] RD_MASK = 17'h0_A901;

  pfpp_if pif ();
  // Short power-on wait and presence window keep the run brief
  pfpp_host #(.POR_CY(4)) pfpp_host_inst (
    .sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en), .port(pif),
    .req_valid(req_valid), .req_read(req_read), .req_sel(req_sel),
    .req_data(req_data), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data));
  pfpp_device #(.EXT_TIMEOUT(20)) pfpp_device_inst (
    .sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
    .test_select(test_select), .prog_enable_a(prog_enable_a),
    .prog_enable_b(prog_enable_b), .ext_clock_in(ext_clock_in),
    .port(pif), .op_start(op_start), .op_kind(op_kind),
    .op_addr(op_addr), .op_wdata(op_wdata), .op_done(op_done),
    .op_rdata(op_rdata), .prog_mode(prog_mode), .ext_clk_sel(ext_clk_sel));
  pfpp_checker pfpp_checker_inst (
    .sys_clk(sys_clk), .reset_n(reset_n),
    .cmd_strobe_n(pif.cmd_strobe_n), .read_enable_n(pif.read_enable_n),
    .field_selector(pif.field_selector), .host_data_o(pif.host_data_o),
    .host_data_oe(pif.host_data_oe), .ready_out(pif.ready_out),
    .ready_oe(pif.ready_oe), .out_flag_n(pif.out_flag_n),
    .out_flag_oe(pif.out_flag_oe), .dev_data_oe(pif.dev_data_oe));

  // ========================================================================
  // Clock, external clock, back end
  // ========================================================================
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // External clock edges every five cycles, well inside the window
  always @(posedge sys_clk) begin
    ext_div <= (ext_div == 4) ? 0 : ext_div + 1;
    if (ext_div == 4) ext_clock_in <= ~ext_clock_in;
  end
  // Back end answers each request three cycles later
  always @(posedge sys_clk) begin
    op_done <= (be_cnt == 3'd1);
    if (op_start === 1'b1) begin
      be_cnt <= 3'd3;
      n_ops++;
      seen_kind = op_kind;
      seen_addr = op_addr[15:0];
      seen_wdata = op_wdata;
      op_rdata <= 16'hC3A0 ^ op_addr[15:0];
    end else if (be_cnt != 3'd0) begin
      be_cnt <= be_cnt - 3'd1;
    end
    if (rsp_valid === 1'b1) rd_word <= rsp_data;
  end

  // ========================================================================
  // Tasks
  // ========================================================================
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // One handshake; request held until the host takes it with req_ready and ready_out both high
  task automatic xfer(input logic rd, input logic [3:0] sel,
                      input logic [15:0] d);
    int n;
    bit lo;
    n = 0;
    lo = 0;
    req_valid <= 1'b1;
    req_read <= rd;
    req_sel <= sel;
    req_data <= d;
    do begin
      @(posedge sys_clk);
      n++;
    end while (!(req_ready === 1'b1 && pif.ready_out === 1'b1) && n < 200);
    req_valid <= 1'b0;
    while (n < 400 && !(lo && pif.ready_out === 1'b1)) begin
      @(posedge sys_clk);
      n++;
      if (pif.ready_out === 1'b0) lo = 1;
    end
    if (n >= 400) check("handshake done", 0, 1);
    repeat (2) @(posedge sys_clk);
  endtask

  // ========================================================================
  // Tests
  // ========================================================================
  initial begin
    failures = 0;
    n_checks = 0;
    n_ops = 0;
    ext_div = 0;
    be_cnt = 3'd0;
    {reset_n, test_select, ext_clock_in, req_valid, req_read} = '0;
    {clk_en, prog_enable_a, prog_enable_b} = 3'b111;
    {req_sel, req_data, op_done, op_rdata} = '0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    check("ready oe in reset", pif.ready_oe, 1'b0);
    check("req ready in reset", req_ready, 1'b0);
    check("bus oe in reset", pif.dev_data_oe, 1'b0);
    // One strap low: the port stays dormant
    repeat (10) @(posedge sys_clk);
    check("mode strap low", prog_mode, 1'b0);
    check("ready oe strap low", pif.ready_oe, 1'b0);
    reset_n <= 1'b0;
    test_select <= 1'b1;
    clk_en <= 1'b0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    // Enable low freezes both ends: no mode entry, power-on wait held
    repeat (5) @(posedge sys_clk);
    check("mode while frozen", prog_mode, 1'b0);
    check("por while frozen", req_ready, 1'b0);
    clk_en <= 1'b1;
    repeat (2) @(posedge sys_clk);
    check("mode entered", prog_mode, 1'b1);
    check("flag after entry", pif.out_flag_n, 1'b0);
    // Next-address word, then the low byte on top of it
    xfer(1'b0, SEL_ADDR_NEXT, 16'h1234);
    check("ext clock chosen", ext_clk_sel, 1'b1);
    xfer(1'b0, SEL_ADDR_LO, 16'hAB56);
    exp_addr = 16'h1256;
    // Every command word, each followed by one data handshake
    for (int i = 0; i < 17; i++) begin
      base = n_ops;
      xfer(1'b0, SEL_CMD, CMD_TAB[i]);
      if (i >= 2 && i <= 5) begin
        check("flush ops", n_ops - base, 1);
        check("flush kind", seen_kind, PFPP_OP_WRITE);
      end
      base = n_ops;
      xfer(RD_MASK[i], SEL_DATA, 16'h5A00 + 16'(i));
      check("op count", n_ops - base, 1);
      check("op kind", seen_kind, KIND_TAB[i]);
      check("op addr", seen_addr, exp_addr);
      if (RD_MASK[i]) check("read word", rd_word, 16'hC3A0 ^ exp_addr);
      else check("write word", seen_wdata, 16'h5A00 + 16'(i));
      exp_addr++;
    end
    // Unmapped selectors complete but change nothing
    base = n_ops;
    xfer(1'b0, 4'h7, CMD_READ);
    xfer(1'b0, 4'hF, 16'h00FF);
    check("ops on idle sel", n_ops - base, 0);
    xfer(1'b0, SEL_DATA, 16'h0F0F);
    check("addr after idle", seen_addr, exp_addr);
    check("cmd after idle", seen_kind, PFPP_OP_PICK_CTRL);
    wrap_up();
  end
  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    wrap_up();
  end
endmodule // parallel_flash_programming_port_tb
